// File: src/itc_pkg.sv
//------------------------------------------------------------
// interval timer constants
//------------------------------------------------------------
package itc_pkg;

	// channel count and counter width
	localparam int NUM_CH = 3;
	localparam int CNT_W  = 16;

	// register byte offsets on the bus
	localparam logic [7:0] CH0_OFF   = 8'h00;
	localparam logic [7:0] CH_STRIDE = 8'h04;
	localparam logic [7:0] CTRL_OFF  = 8'h0c;
	localparam logic [7:0] STAT_OFF  = 8'h10;

	// control word field positions
	localparam int CW_BCD_BIT = 0;
	localparam int CW_MODE_LO = 1;
	localparam int CW_ACC_LO  = 4;
	localparam int CW_SEL_LO  = 6;

	// channel pick value that selects nothing
	localparam logic [1:0] SEL_NONE = 2'h3;

	// byte access order codes
	localparam logic [1:0] ACC_LATCH = 2'h0;
	localparam logic [1:0] ACC_LO    = 2'h1;
	localparam logic [1:0] ACC_HI    = 2'h2;
	localparam logic [1:0] ACC_BOTH  = 2'h3;

	// decoded operating modes
	localparam logic [2:0] MODE_TC   = 3'h0;
	localparam logic [2:0] MODE_OS   = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQ   = 3'h3;
	localparam logic [2:0] MODE_SWS  = 3'h4;
	localparam logic [2:0] MODE_HWS  = 3'h5;

	// reset values
	localparam logic [2:0]  MODE_RST = MODE_TC;
	localparam logic [1:0]  ACC_RST  = ACC_LO;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic        OUT_RST  = 1'b1;

endpackage

// File: src/count_step.sv
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------
// down step by 1..3 in binary or four bcd digits
//------------------------------------------------------------
module count_step
(
	// value and format
	input  wire logic [15:0] i_value,
	input  wire logic        i_bcd,
	input  wire logic [1:0]  i_step,
	// result
	output logic      [15:0] o_value,
	output logic             o_borrow
);

	// digit borrow chain, binary path overrides
	always_comb
	begin
		logic [4:0] dig;
		logic [3:0] sub;
		dig      = 5'h00;
		sub      = {2'h0, i_step};
		o_value  = 16'h0000;
		o_borrow = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			dig = {1'b0, i_value[i*4 +: 4]} - {1'b0, sub};
			if (dig[4])
			begin
				dig = dig + 5'h0a; // wrap digit to 9..7
				sub = 4'h1;
			end
			else
			begin
				sub = 4'h0;
			end
			o_value[i*4 +: 4] = dig[3:0];
		end
		o_borrow = sub[0];
		if (!i_bcd)
			{o_borrow, o_value} = {1'b0, i_value} - {15'h0000, i_step};
	end

endmodule // count_step
`default_nettype wire

// File: src/interval_timer.sv
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------
// three channel interval timer, ahb-lite register slave
//------------------------------------------------------------
// Behaviour
// - access field: 00 latch, 10 high only, 01 low only, 11 low then high.
// - format bit clear counts binary 16-bit, set counts four bcd digits.
// - count loads after all bytes, then a count clock rise and fall.
// - mode 0 output low from mode set, high at terminal count.
// - mode 0 keeps decrementing past terminal count.
// - mode 0 first byte halts counting, second byte starts the new count.
// - mode 1 output low on clock after gate rise, high at terminal.
// - mode 1 new count waits for next trigger; reads never disturb.
// - mode 1 each gate rise retriggers a full count.
// - mode 2 divides by n, output low for one clock per period.
// - mode 2 rewritten count applies from the following period.
// - modes 2 and 3 low gate stops and forces high; rise reloads.
// - mode 2 output stays high until a count has been loaded.
// - mode 3 even count steps by two, toggles and reloads at terminal.
// - mode 3 odd count: first high step one, first low step three.
// - mode 4 high at mode set, low one clock at terminal count.
// - mode 4 rewrite taken next clock; modes 0, 4 pause on low gate.
// - mode 5 counts after gate rise, one clock low, retriggerable.
// - loaded zero counts as 65536 binary or 10000 bcd.
// - control word taken at the control offset; it reads as zero.
// - three identical channels, each with own counter and control word.
module interval_timer
	import itc_pkg::*;
(
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_NRST,
	// ahb-lite slave
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP,
	// timer pins
	input  wire logic [2:0]  I_CNT_CLK,
	input  wire logic [2:0]  I_GATE,
	output logic      [2:0]  O_OUT
);

	//------------------------------------------------------------
	// bus side
	//------------------------------------------------------------
	logic        accept;
	logic        wr_pend_reg;
	logic [7:0]  waddr_reg;
	logic [31:0] rdata_reg;
	logic [7:0]  wbyte;
	logic        cw_wr;
	logic [1:0]  cw_sel;
	logic [1:0]  cw_acc;
	logic [2:0]  cw_mode;
	logic [2:0]  out_w;
	logic [2:0]  armed_w;
	logic [7:0]  rd_byte_w [NUM_CH];

	// address phase accepted; size is not checked, low byte used
	assign accept = I_HSEL & I_HTRANS[1] & I_HREADY;
	assign wbyte  = I_HWDATA[7:0];

	// control word fields from the data phase byte
	assign cw_sel = wbyte[CW_SEL_LO +: 2];
	assign cw_acc = wbyte[CW_ACC_LO +: 2];
	assign cw_wr  = wr_pend_reg & (waddr_reg == CTRL_OFF)
		& (cw_sel != SEL_NONE);

	// mode field decode, top bit ignored for modes 2 and 3
	always_comb
	begin
		if (wbyte[CW_MODE_LO + 1])
			cw_mode = {1'b0, wbyte[CW_MODE_LO +: 2]};
		else
			cw_mode = wbyte[CW_MODE_LO +: 3];
	end

	// write address held into the data phase
	always_ff @(posedge I_CLK)
	begin
		if (!I_NRST)
		begin
			wr_pend_reg <= 1'b0;
			waddr_reg   <= 8'h00;
		end
		else
		begin
			wr_pend_reg <= accept & I_HWRITE;
			if (accept)
				waddr_reg <= I_HADDR[7:0];
		end
	end

	// read data captured at the address phase edge
	always_ff @(posedge I_CLK)
	begin
		if (!I_NRST)
			rdata_reg <= 32'h00000000;
		else if (accept && !I_HWRITE)
		begin
			rdata_reg <= 32'h00000000; // control and unmapped read zero
			for (int c = 0; c < NUM_CH; c++)
				if (I_HADDR[7:0] == CH0_OFF + CH_STRIDE * 8'(c))
					rdata_reg[7:0] <= rd_byte_w[c];
			if (I_HADDR[7:0] == STAT_OFF)
				rdata_reg[5:0] <= {armed_w, out_w};
		end
	end

	assign O_HRDATA    = rdata_reg;
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP     = 1'b0;
	assign O_OUT       = out_w;

	//------------------------------------------------------------
	// counter channels
	//------------------------------------------------------------
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ch
		logic [2:0]  mode_reg;
		logic [1:0]  acc_reg;
		logic        bcd_reg;
		logic [15:0] count_reg;
		logic [15:0] init_reg;
		logic [15:0] hold_reg;
		logic [15:0] latch_reg;
		logic        lo_done_reg;
		logic        pend_reg;
		logic        rise_seen_reg;
		logic        armed_reg;
		logic        halt_reg;
		logic        out_reg;
		logic        trig_reg;
		logic        first_reg;
		logic        latched_reg;
		logic        rd_msb_reg;
		logic        ck_d_reg;
		logic        gate_d_reg;
		logic        ck_rise;
		logic        ck_fall;
		logic        gate_rise;
		logic        cw_hit;
		logic        cw_cfg;
		logic        cw_lat;
		logic        wr_hit;
		logic        rd_hit;
		logic        load_now;
		logic        run;
		logic        tc;
		logic        borrow;
		logic        sq;
		logic [1:0]  step;
		logic [15:0] next_cnt;
		logic [15:0] rd_src;

		// edges of the count clock and gate
		assign ck_rise   = I_CNT_CLK[g] & ~ck_d_reg;
		assign ck_fall   = ck_d_reg & ~I_CNT_CLK[g];
		assign gate_rise = I_GATE[g] & ~gate_d_reg;

		// strobes for this channel
		assign cw_hit = cw_wr & (cw_sel == 2'(g));
		assign cw_cfg = cw_hit & (cw_acc != ACC_LATCH);
		assign cw_lat = cw_hit & (cw_acc == ACC_LATCH);
		assign wr_hit = wr_pend_reg
			& (waddr_reg == CH0_OFF + CH_STRIDE * 8'(g));
		assign rd_hit = accept & ~I_HWRITE
			& (I_HADDR[7:0] == CH0_OFF + CH_STRIDE * 8'(g));
		assign load_now = pend_reg & rise_seen_reg & ck_fall;

		// step size: square wave by two, odd first steps one or three
		assign sq = (mode_reg == MODE_SQ);
		always_comb
		begin
			if (sq && first_reg && init_reg[0])
				step = out_reg ? 2'h1 : 2'h3;
			else if (sq)
				step = 2'h2;
			else
				step = 2'h1;
		end

		// binary or bcd decrement; zero wraps so it counts the maximum
		count_step u_step
		(
			.i_value  (count_reg),
			.i_bcd    (bcd_reg),
			.i_step   (step),
			.o_value  (next_cnt),
			.o_borrow (borrow)
		);

		assign tc = (next_cnt == CNT_RST)
			| (sq & borrow & (count_reg != CNT_RST));

		// gated modes pause on low gate
		always_comb
		begin
			unique case (mode_reg)
				MODE_TC:   run = I_GATE[g] & ~halt_reg;
				MODE_SWS:  run = I_GATE[g];
				MODE_RATE,
				MODE_SQ:   run = I_GATE[g];
				default:   run = 1'b1;
			endcase
		end

		// pin edge samples
		always_ff @(posedge I_CLK)
		begin
			if (!I_NRST)
			begin
				ck_d_reg   <= 1'b0;
				gate_d_reg <= 1'b1; // idle high gate gives no edge
			end
			else
			begin
				ck_d_reg   <= I_CNT_CLK[g];
				gate_d_reg <= I_GATE[g];
			end
		end

		// control word storage
		always_ff @(posedge I_CLK)
		begin
			if (!I_NRST)
			begin
				mode_reg <= MODE_RST;
				acc_reg  <= ACC_RST;
				bcd_reg  <= 1'b0;
			end
			else if (cw_cfg)
			begin
				mode_reg <= cw_mode;
				acc_reg  <= cw_acc;
				bcd_reg  <= wbyte[CW_BCD_BIT];
			end
		end

		// count byte assembly and pending load
		always_ff @(posedge I_CLK)
		begin
			if (!I_NRST)
			begin
				hold_reg      <= CNT_RST;
				lo_done_reg   <= 1'b0;
				pend_reg      <= 1'b0;
				rise_seen_reg <= 1'b0;
			end
			else if (cw_cfg)
			begin
				lo_done_reg   <= 1'b0;
				pend_reg      <= 1'b0;
				rise_seen_reg <= 1'b0;
			end
			else if (wr_hit)
			begin
				rise_seen_reg <= 1'b0;
				unique case (acc_reg)
					ACC_LO:
					begin
						hold_reg <= {8'h00, wbyte};
						pend_reg <= 1'b1;
					end
					ACC_HI:
					begin
						hold_reg <= {wbyte, 8'h00};
						pend_reg <= 1'b1;
					end
					ACC_BOTH:
					begin
						if (!lo_done_reg)
						begin
							hold_reg[7:0] <= wbyte;
							lo_done_reg   <= 1'b1;
						end
						else
						begin
							hold_reg[15:8] <= wbyte;
							lo_done_reg    <= 1'b0;
							pend_reg       <= 1'b1;
						end
					end
					default: ;
				endcase
			end
			else if (load_now)
				pend_reg <= 1'b0;
			else if (pend_reg && ck_rise)
				rise_seen_reg <= 1'b1;
		end

		// counting element and output
		always_ff @(posedge I_CLK)
		begin
			if (!I_NRST)
			begin
				count_reg <= CNT_RST;
				init_reg  <= CNT_RST;
				armed_reg <= 1'b0;
				halt_reg  <= 1'b0;
				out_reg   <= OUT_RST;
				trig_reg  <= 1'b0;
				first_reg <= 1'b0;
			end
			else if (cw_cfg)
			begin
				armed_reg <= 1'b0;
				halt_reg  <= 1'b0;
				trig_reg  <= 1'b0;
				out_reg   <= (cw_mode != MODE_TC);
			end
			else
			begin
				if (wr_hit && mode_reg == MODE_TC && acc_reg == ACC_BOTH
					&& !lo_done_reg)
					halt_reg <= 1'b1;
				if (gate_rise)
					trig_reg <= 1'b1;
				if ((mode_reg == MODE_RATE || sq) && !I_GATE[g])
					out_reg <= 1'b1;
				if (ck_fall)
				begin
					// strobe modes end their one clock low pulse
					if ((mode_reg == MODE_SWS || mode_reg == MODE_HWS)
						&& !out_reg)
						out_reg <= 1'b1;
					// armed rate and square modes keep counting on a load edge
					if (load_now)
						init_reg <= hold_reg;
					if (load_now && !(armed_reg
						&& (mode_reg == MODE_RATE || sq)))
					begin
						unique case (mode_reg)
							MODE_TC:
							begin
								count_reg <= hold_reg;
								armed_reg <= 1'b1;
								halt_reg  <= 1'b0;
								out_reg   <= 1'b0;
							end
							MODE_SWS:
							begin
								count_reg <= hold_reg;
								armed_reg <= 1'b1;
							end
							MODE_RATE,
							MODE_SQ:
							begin
								if (!armed_reg)
								begin
									count_reg <= hold_reg;
									armed_reg <= 1'b1;
									first_reg <= 1'b1;
								end
							end
							default: ; // waits for a trigger
						endcase
					end
					else if (trig_reg && (mode_reg == MODE_OS
						|| mode_reg == MODE_HWS))
					begin
						count_reg <= init_reg;
						armed_reg <= 1'b1;
						trig_reg  <= 1'b0;
						if (mode_reg == MODE_OS)
							out_reg <= 1'b0;
					end
					else if (trig_reg && (mode_reg == MODE_RATE || sq)
						&& I_GATE[g])
					begin
						count_reg <= init_reg;
						armed_reg <= 1'b1;
						first_reg <= 1'b1;
						trig_reg  <= 1'b0;
						out_reg   <= 1'b1;
					end
					else if (armed_reg && run)
					begin
						first_reg <= 1'b0;
						count_reg <= next_cnt;
						unique case (mode_reg)
							MODE_TC:
								if (tc)
									out_reg <= 1'b1;
							MODE_OS:
								if (tc)
								begin
									out_reg   <= 1'b1;
									armed_reg <= 1'b0;
								end
							MODE_RATE:
								if (tc)
								begin
									count_reg <= init_reg;
									out_reg   <= 1'b1;
								end
								else
									out_reg <= (next_cnt != 16'h0001);
							MODE_SQ:
								if (tc)
								begin
									count_reg <= init_reg;
									out_reg   <= ~out_reg;
									first_reg <= 1'b1;
								end
							default:
								if (tc)
								begin
									out_reg   <= 1'b0;
									armed_reg <= 1'b0;
								end
						endcase
					end
				end
			end
		end

		// count latch and read byte order; reads leave counting alone
		always_ff @(posedge I_CLK)
		begin
			if (!I_NRST)
			begin
				latch_reg   <= CNT_RST;
				latched_reg <= 1'b0;
				rd_msb_reg  <= 1'b0;
			end
			else if (cw_lat && !latched_reg)
			begin
				latch_reg   <= count_reg;
				latched_reg <= 1'b1;
			end
			else if (cw_cfg)
			begin
				latched_reg <= 1'b0;
				rd_msb_reg  <= 1'b0;
			end
			else if (rd_hit)
			begin
				if (acc_reg == ACC_BOTH && !rd_msb_reg)
					rd_msb_reg <= 1'b1;
				else
				begin
					rd_msb_reg  <= 1'b0;
					latched_reg <= 1'b0;
				end
			end
		end

		assign rd_src = latched_reg ? latch_reg : count_reg;
		assign rd_byte_w[g] = (acc_reg == ACC_HI
			|| (acc_reg == ACC_BOTH && rd_msb_reg))
			? rd_src[15:8] : rd_src[7:0];
		assign out_w[g]   = out_reg;
		assign armed_w[g] = armed_reg;
	end

endmodule // interval_timer
`default_nettype wire

// File: test/pin_model.sv
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------
// count clock source for the three channels
//------------------------------------------------------------
module pin_model
(
	// system clock
	input  wire logic       i_clk,
	// per channel run request
	input  wire logic [2:0] i_go,
	// count clocks
	output var logic  [2:0] o_cnt_clk = 3'h0
);
	logic [1:0] ph [3];

	// two cycles high, two low, held low while idle
	always @(posedge i_clk)
	begin
		for (int c = 0; c < 3; c++)
		begin
			ph[c] <= i_go[c] ? ph[c] + 2'h1 : 2'h0;
			o_cnt_clk[c] <= i_go[c] && ph[c] < 2'h2; // rise then fall
		end
	end
endmodule // pin_model
`default_nettype wire

// File: test/itc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------
// port checker, channel 0 and bus
//------------------------------------------------------------
module itc_monitor
	import itc_pkg::*;
(
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_NRST,
	// bus
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	input  wire logic [31:0] O_HRDATA,
	// pins
	input  wire logic [2:0]  I_CNT_CLK,
	input  wire logic [2:0]  I_GATE,
	input  wire logic [2:0]  O_OUT
);
	logic [7:0] a_q;
	logic       w_q, r_q, c_q, g_q;
	logic [2:0] m_q;
	logic [3:0] since;
	wire  [2:0] wm = I_HWDATA[2] ? {1'b0, I_HWDATA[2:1]} : I_HWDATA[3:1];
	wire        cw = w_q && a_q == CTRL_OFF && I_HWDATA[7:4] != 4'h0
		&& I_HWDATA[7:6] == 2'h0;
	wire        ev = w_q || I_CNT_CLK[0] != c_q || I_GATE[0] != g_q;

	// bus phase tracking and channel 0 mode copy
	always_ff @(posedge I_CLK)
	begin
		a_q <= I_HADDR[7:0];
		c_q <= I_CNT_CLK[0];
		g_q <= I_GATE[0];
		w_q <= I_NRST && I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE;
		r_q <= I_NRST && I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE;
		m_q <= !I_NRST ? MODE_TC : (cw ? wm : m_q);
		since <= (!I_NRST || ev) ? 4'h0 : since + {3'h0, since != 4'hf};
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);

	ctrl_read_a: assert property (
		r_q && a_q == CTRL_OFF |-> O_HRDATA == 32'h0)
		else $error("control word read not zero");
	tc_init_a: assert property (
		cw && wm == MODE_TC |-> ##[1:3] !O_OUT[0])
		else $error("mode 0 set without low output");
	rate_init_a: assert property (
		cw && wm == MODE_RATE |-> ##[1:3] O_OUT[0][*3])
		else $error("mode 2 set without high output");
	sw_init_a: assert property (
		cw && wm == MODE_SWS |-> ##[1:3] O_OUT[0])
		else $error("mode 4 set without high output");
	gate_high_a: assert property (
		(m_q == MODE_RATE || m_q == MODE_SQ) && !I_GATE[0] |-> ##[0:3] O_OUT[0])
		else $error("low gate did not force output high");
	rate_pulse_a: assert property (
		m_q == MODE_RATE && !O_OUT[0] && c_q && !I_CNT_CLK[0]
		|-> ##1 O_OUT[0])
		else $error("rate pulse longer than one count clock");
	sw_pulse_a: assert property (
		m_q == MODE_SWS && !O_OUT[0] && c_q && !I_CNT_CLK[0]
		|-> ##1 O_OUT[0])
		else $error("software strobe longer than one count clock");
	hw_pulse_a: assert property (
		m_q == MODE_HWS && !O_OUT[0] && c_q && !I_CNT_CLK[0]
		|-> ##1 O_OUT[0])
		else $error("hardware strobe longer than one count clock");
	out_cause_a: assert property (
		$changed(O_OUT[0]) |-> since < 4'h8)
		else $error("output moved without a cause");

	cover property (cw && wm == MODE_HWS);
	cover property (m_q == MODE_RATE && $fell(O_OUT[0]));
	cover property (r_q && a_q == CTRL_OFF);
endmodule // itc_monitor

bind interval_timer itc_monitor u_mon (.I_CLK(I_CLK), .I_NRST(I_NRST),
	.I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
	.I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
	.O_HRDATA(O_HRDATA), .I_CNT_CLK(I_CNT_CLK), .I_GATE(I_GATE),
	.O_OUT(O_OUT));
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------
// timer bench
//------------------------------------------------------------
module tb
	import itc_pkg::*;
;
	logic        clk, nrst, hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize, go, gate, cclk, out;
	int          num_errors = 0;
	int          n_tests = 0;

	// design and count clock source
	interval_timer dut (.I_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
		.O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
		.I_CNT_CLK(cclk), .I_GATE(gate), .O_OUT(out));
	pin_model u_pins (.i_clk(clk), .i_go(go), .o_cnt_clk(cclk));

	// 50 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// verdict and compares
	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic cko(input int c, input logic e);
		repeat (2) @(posedge clk);
		chk({31'h0, out[c]}, {31'h0, e});
	endtask

	// one single bus transfer, address then data phase
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] r);
		int k;
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		for (int p = 0; p < 2; p++)
		begin
			k = 0;
			@(posedge clk);
			while (hready !== 1'b1 && k < 50)
			begin
				@(posedge clk);
				k++;
			end
			if (k == 50)
			begin
				num_errors++;
				give_verdict();
			end
			if (p == 0)
			begin
				htrans <= 2'h0;
				hwdata <= {24'h0, d};
			end
		end
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 8'h0, r);
		chk(r, e);
	endtask

	// latch channel 0, read low then high byte
	task automatic lat(input logic [15:0] v);
		wr(CTRL_OFF, 8'h00);
		rd(CH0_OFF, {24'h0, v[7:0]});
		rd(CH0_OFF, {24'h0, v[15:8]});
	endtask

	task automatic tick(input int c, input int n);
		go[c] <= 1'b1;
		repeat (4 * n) @(posedge clk);
		go[c] <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic gt(input int c, input logic v);
		gate[c] <= v;
		repeat (3) @(posedge clk);
	endtask

	// main sequence
	initial
	begin
		int sq[2] = '{4, 5};
		{nrst, hsel, hwrite, htrans, go} = '0;
		{haddr, hwdata} = '0;
		hsize = 3'h2;
		gate = 3'h7;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(8'h14, 32'h0);
		rd(CTRL_OFF, 32'h0);
		wr(CTRL_OFF, 8'h31);
		cko(0, 1'b0);
		wr(CH0_OFF, 8'h02);
		wr(CH0_OFF, 8'h00);
		tick(0, 2);
		cko(0, 1'b0);
		tick(0, 1);
		cko(0, 1'b1);
		tick(0, 1);
		lat(16'h9999);
		gt(0, 1'b0);
		tick(0, 2);
		lat(16'h9999);
		gt(0, 1'b1);
		wr(CH0_OFF, 8'h05);
		tick(0, 2);
		lat(16'h9999);
		wr(CH0_OFF, 8'h00);
		tick(0, 5);
		cko(0, 1'b0);
		tick(0, 1);
		cko(0, 1'b1);
		wr(CTRL_OFF, 8'h1c);
		tick(0, 3);
		cko(0, 1'b1);
		wr(CH0_OFF, 8'h03);
		tick(0, 3);
		cko(0, 1'b0);
		tick(0, 1);
		cko(0, 1'b1);
		wr(CH0_OFF, 8'h04);
		tick(0, 2);
		cko(0, 1'b0);
		tick(0, 3);
		cko(0, 1'b1);
		tick(0, 1);
		cko(0, 1'b0);
		gt(0, 1'b0);
		cko(0, 1'b1);
		gt(0, 1'b1);
		tick(0, 3);
		cko(0, 1'b1);
		tick(0, 1);
		cko(0, 1'b0);
		wr(CTRL_OFF, 8'h18);
		cko(0, 1'b1);
		wr(CH0_OFF, 8'h02);
		tick(0, 3);
		cko(0, 1'b0);
		tick(0, 1);
		cko(0, 1'b1);
		wr(CTRL_OFF, 8'h1a);
		wr(CH0_OFF, 8'h02);
		tick(0, 2);
		cko(0, 1'b1);
		gt(0, 1'b0);
		gt(0, 1'b1);
		tick(0, 3);
		cko(0, 1'b0);
		wr(CTRL_OFF, 8'h52);
		wr(CH0_OFF + CH_STRIDE, 8'h02);
		tick(1, 1);
		gt(1, 1'b0);
		gt(1, 1'b1);
		tick(1, 2);
		cko(1, 1'b0);
		gt(1, 1'b0);
		gt(1, 1'b1);
		tick(1, 2);
		cko(1, 1'b0);
		tick(1, 1);
		cko(1, 1'b1);
		foreach (sq[i])
		begin
			wr(CTRL_OFF, 8'h9e);
			wr(CH0_OFF + 8'h08, 8'(sq[i]));
			gt(2, 1'b0);
			gt(2, 1'b1);
			tick(2, 2);
			for (int k = 1; k <= sq[i]; k++)
			begin
				tick(2, 1);
				cko(2, !(k >= (sq[i] + 1) / 2 && k < sq[i]));
			end
		end
		give_verdict();
	end
endmodule // tb
`default_nettype wire
